//--- rtl/crossbar_switch_pkg.sv
// Constants and carrier types for the crossbar switch slave-port arbiters.
// Assumes one clock domain and masters that hold a request for as long as they
// want to keep a slave port.
package crossbar_switch_pkg;

  localparam int NUM_MASTERS = 5;
  localparam int NUM_SLAVES = 8;
  localparam int MASTER_W = 3;
  localparam int SLAVE_W = 3;
  localparam int CFG_W = 32;

  // Priority word: one field per master port, a lower value wins.
  localparam int PRIO_FIELD_W = 4;
  localparam logic [CFG_W-1:0] PRIO_RESET = 32'h7654_3210;

  // Control word: park master in the low field, arbitration mode bit above it.
  localparam int PARK_LSB = 0;
  localparam int ARB_MODE_BIT = 8;
  localparam logic [CFG_W-1:0] CTRL_RESET = 32'h0000_0000;

  // Master port of the processor bus; owns every idle slave port after reset.
  localparam logic [MASTER_W-1:0] CPU_MASTER = 3'h0;

  typedef enum logic {
    ARB_FIXED,
    ARB_ROUND_ROBIN
  } arb_mode_t;

  typedef enum logic {
    SEL_CONTROL,
    SEL_PRIORITY
  } cfg_sel_t;

  // One master's request: asserted while it wants the addressed slave port.
  typedef struct packed {
    logic req;
    logic [SLAVE_W-1:0] slave;
  } master_req_t;

  // Configuration load: writes one word of one slave port's settings.
  typedef struct packed {
    logic we;
    cfg_sel_t sel;
    logic [SLAVE_W-1:0] slave;
    logic [CFG_W-1:0] data;
  } cfg_wr_t;

  // State of one slave port as the masters see it.
  typedef struct packed {
    logic busy;
    logic [MASTER_W-1:0] owner;
  } slave_state_t;

endpackage : crossbar_switch_pkg

//--- rtl/crossbar_switch.sv
// Crossbar switch: one arbiter per slave port, all running in parallel.
// Masters present a request and a slave index; a master may drive its transfer
// in any cycle in which the slave it addresses shows it as owner, and stalls
// otherwise. Settings arrive through a plain load port, not a software bus.
// Assumes masters hold their request for the whole time they want a port and
// drop it for at least one cycle to let the next master in.
`timescale 1ns/10ps

// Operation
// - Different slave ports serve different masters concurrently
// - Contention in fixed mode grants the higher-priority requesting master
// - Losers stall until winner finishes its transfers
// - Fixed priority at reset, round-robin selectable
// - Default: processor bus highest priority, parked there
// - Control value 4 parks slave 3 on master 4
// - Priority value 0x321 makes master 4 highest
module crossbar_switch
  import crossbar_switch_pkg::*;
#(
  parameter int N_MASTERS = NUM_MASTERS,
  parameter int N_SLAVES = NUM_SLAVES
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire master_req_t master_req [N_MASTERS],
  input wire cfg_wr_t cfg_wr,
  output slave_state_t slave_state [N_SLAVES],
  output logic [N_MASTERS-1:0] master_stall
);

  logic [CFG_W-1:0] prio_q [N_SLAVES];
  logic [CFG_W-1:0] ctrl_q [N_SLAVES];
  slave_state_t state_q [N_SLAVES];
  slave_state_t state_d [N_SLAVES];
  logic [N_MASTERS-1:0] stall_q;
  logic [N_MASTERS-1:0] stall_d;

  // Requests aimed at one slave port.
  function automatic logic [N_MASTERS-1:0] reqs_for(input int s,
                                                     input master_req_t r [N_MASTERS]);
    logic [N_MASTERS-1:0] v;
    v = '0;
    for (int m = 0; m < N_MASTERS; m++) begin
      v[m] = r[m].req && (r[m].slave == SLAVE_W'(s));
    end
    return v;
  endfunction : reqs_for

  // Equal fields go to the higher port number: a priority word that leaves two
  // ports at level zero still names a single top master.
  function automatic logic outranks(input logic [PRIO_FIELD_W-1:0] p,
                                    input logic [PRIO_FIELD_W-1:0] best_p);
    return p <= best_p;
  endfunction : outranks

  // Lowest priority field wins.
  function automatic logic [MASTER_W-1:0] pick_fixed(input logic [N_MASTERS-1:0] v,
                                                     input logic [CFG_W-1:0] prio);
    logic [MASTER_W-1:0] best;
    logic [PRIO_FIELD_W-1:0] best_p;
    logic found;
    logic [PRIO_FIELD_W-1:0] p;
    best = '0;
    best_p = '1;
    found = 1'b0;
    for (int m = 0; m < N_MASTERS; m++) begin
      p = prio[m*PRIO_FIELD_W +: PRIO_FIELD_W];
      if (v[m] && (!found || outranks(p, best_p))) begin
        best = MASTER_W'(m);
        best_p = p;
        found = 1'b1;
      end
    end
    return best;
  endfunction : pick_fixed

  // Search starts just after the last owner, so every requester gets a turn.
  function automatic logic [MASTER_W-1:0] pick_rr(input logic [N_MASTERS-1:0] v,
                                                  input logic [MASTER_W-1:0] last);
    logic [MASTER_W-1:0] best;
    logic found;
    int idx;
    best = last;
    found = 1'b0;
    for (int k = 1; k <= N_MASTERS; k++) begin
      idx = (int'(last) + k) % N_MASTERS;
      if (!found && v[idx]) begin
        best = MASTER_W'(idx);
        found = 1'b1;
      end
    end
    return best;
  endfunction : pick_rr

  // A park field naming a port that does not exist falls back to the processor
  // bus, so an idle slave port is never left owned by nobody.
  function automatic logic [MASTER_W-1:0] park_of(input logic [CFG_W-1:0] ctrl);
    logic [MASTER_W-1:0] p;
    p = ctrl[PARK_LSB +: MASTER_W];
    if (int'(p) >= N_MASTERS) begin
      p = CPU_MASTER;
    end
    return p;
  endfunction : park_of

  // A clear mode bit selects fixed priority, so a plain park write keeps it.
  function automatic arb_mode_t mode_of(input logic [CFG_W-1:0] ctrl);
    return arb_mode_t'(ctrl[ARB_MODE_BIT]);
  endfunction : mode_of

  // An owner that drops its request for a single cycle gives the port up.
  function automatic logic owner_keeps(input slave_state_t st,
                                       input logic [N_MASTERS-1:0] v);
    return st.busy && (int'(st.owner) < N_MASTERS) && v[st.owner];
  endfunction : owner_keeps

  function automatic logic must_wait(input master_req_t r,
                                     input logic [MASTER_W-1:0] next_owner,
                                     input int m);
    return r.req && (next_owner != MASTER_W'(m));
  endfunction : must_wait

  // A load lands only on a slave port that exists; other indices are dropped.
  function automatic logic cfg_hit(input cfg_wr_t w, input cfg_sel_t sel);
    return w.we && (w.sel == sel) && (int'(w.slave) < N_SLAVES);
  endfunction : cfg_hit

  // Reset puts the processor bus on top of every priority word.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int s = 0; s < N_SLAVES; s++) begin
        prio_q[s] <= PRIO_RESET;
      end
    end else if (cfg_hit(cfg_wr, SEL_PRIORITY)) begin
      prio_q[cfg_wr.slave] <= cfg_wr.data;
    end
  end

  // Reset parks every idle port on the processor bus in fixed mode.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int s = 0; s < N_SLAVES; s++) begin
        ctrl_q[s] <= CTRL_RESET;
      end
    end else if (cfg_hit(cfg_wr, SEL_CONTROL)) begin
      ctrl_q[cfg_wr.slave] <= cfg_wr.data;
    end
  end

  // Each slave port decides on its own, so unrelated transfers never wait.
  generate
    for (genvar s = 0; s < N_SLAVES; s++) begin : g_slave
      logic [N_MASTERS-1:0] req_v;
      logic [MASTER_W-1:0] park;
      arb_mode_t mode;
      always_comb begin
        req_v = reqs_for(s, master_req);
        park = park_of(ctrl_q[s]);
        mode = mode_of(ctrl_q[s]);
        state_d[s] = state_q[s];
        if (owner_keeps(state_q[s], req_v)) begin
          // Owner keeps the port until it drops its request.
          state_d[s].busy = 1'b1;
        end else if (req_v != '0) begin
          state_d[s].busy = 1'b1;
          if (mode == ARB_ROUND_ROBIN) begin
            state_d[s].owner = pick_rr(req_v, state_q[s].owner);
          end else begin
            state_d[s].owner = pick_fixed(req_v, prio_q[s]);
          end
        end else begin
          state_d[s].busy = 1'b0;
          state_d[s].owner = park;
        end
      end
    end
  endgenerate

  // A master whose next cycle's slave is not owned by it must wait.
  always_comb begin
    for (int m = 0; m < N_MASTERS; m++) begin
      stall_d[m] = 1'h0;
      if (int'(master_req[m].slave) < N_SLAVES) begin
        stall_d[m] = must_wait(master_req[m],
                               state_d[master_req[m].slave].owner, m);
      end
    end
  end

  // Owner resets to the processor bus, the port that the reset control word
  // parks on, so the first idle cycle after reset changes nothing.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int s = 0; s < N_SLAVES; s++) begin
        state_q[s].busy <= 1'b0;
        state_q[s].owner <= CPU_MASTER;
      end
    end else begin
      for (int s = 0; s < N_SLAVES; s++) begin
        state_q[s] <= state_d[s];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      stall_q <= '0;
    end else begin
      stall_q <= stall_d;
    end
  end

  always_comb begin
    for (int s = 0; s < N_SLAVES; s++) begin
      slave_state[s] = state_q[s];
    end
  end
  assign master_stall = stall_q;

endmodule : crossbar_switch

//--- tb/crossbar_switch_monitor.sv
// Assertion checker on the crossbar switch ports.
// Assumes contention on slave 0 comes only from masters 1, 2, 3 and 4.
`timescale 1ns/10ps
module crossbar_switch_monitor
  import crossbar_switch_pkg::*;
#(parameter int N_MASTERS = 5, parameter int N_SLAVES = 8) (
  input wire logic core_clk,
  input wire logic srst,
  input wire master_req_t master_req [N_MASTERS],
  input wire cfg_wr_t cfg_wr,
  input wire slave_state_t slave_state [N_SLAVES],
  input wire logic [N_MASTERS-1:0] master_stall
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_park3;
    cfg_wr == {1'b1, SEL_CONTROL, 3'h3, 32'h4} ##1 !slave_state[3].busy [*2];
  endsequence
  a_reset_park: assert property (
    $fell(srst) |-> slave_state[3] == 4'h0 && master_stall == 5'h0) else $error("reset state");
  a_fixed_win: assert property (
    master_req[1] == 4'h8 && master_req[2] == 4'h8 && !slave_state[0].busy
    |=> slave_state[0] == 4'h9 && master_stall[2]) else $error("wrong winner");
  a_owner_kept: assert property (
    slave_state[0].busy && master_req[slave_state[0].owner] == 4'h8
    |=> $stable(slave_state[0])) else $error("owner lost port");
  a_stall_tracks: assert property (
    !$past(srst) && $past(master_req[2]) == 4'h8
    |-> master_stall[2] == (slave_state[0].owner != 3'h2)) else $error("stall wrong");
  a_grant_cause: assert property (
    slave_state[2] == 4'hB |-> $past(master_req[3]) == 4'hA) else $error("grant unasked");
  a_park_fast: assert property (
    master_req[0] == 4'hD && slave_state[5] == 4'h0
    |=> slave_state[5] == 4'h8 && !master_stall[0]) else $error("park delay");
  a_stall_req: assert property (
    master_stall[1] |-> $past(master_req[1].req)) else $error("idle stalled");
  a_cfg_park: assert property (
    s_park3 |-> slave_state[3].owner == 3'h4) else $error("park not moved");
endmodule : crossbar_switch_monitor
bind crossbar_switch crossbar_switch_monitor #(.N_MASTERS(N_MASTERS), .N_SLAVES(N_SLAVES))
  mon_u (.core_clk, .srst, .master_req, .cfg_wr, .slave_state, .master_stall);

//--- tb/master_model.sv
// Bus master model: keeps its request until it has owned the port three cycles.
// Assumes start is a one-cycle pulse set at a falling edge.
`timescale 1ns/10ps
module master_model
  import crossbar_switch_pkg::*;
(
  input wire logic core_clk,
  input wire logic start,
  input wire logic [SLAVE_W-1:0] target,
  input wire logic stall,
  output master_req_t req = '0
);
  logic [1:0] left_q = '0;
  // A stalled master waits with its request held and its count frozen.
  always @(negedge core_clk) begin
    if (start && !req.req) begin
      req <= {1'b1, target};
      left_q <= 2'h2;
    end else if (req.req && !stall) begin
      left_q <= left_q - 2'h1;
      if (left_q == 2'h0) req <= {1'b0, ~req.slave};
    end
  end
endmodule : master_model

//--- tb/testbench.sv
// Self-checking bench for the crossbar switch with five master models.
// Assumes the checker binds itself into the switch.
`timescale 1ns/10ps
module testbench
  import crossbar_switch_pkg::*;
;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [4:0] start = '0;
  logic [2:0] tgt [5] = '{default: '0};
  master_req_t master_req [5];
  cfg_wr_t cfg_wr = '0;
  slave_state_t slave_state [8];
  logic [4:0] master_stall;
  int bad_count = 0, checks = 0, cyc = 0;
  always #5 core_clk = ~core_clk;
  crossbar_switch dut_u (.core_clk, .srst, .master_req, .cfg_wr, .slave_state, .master_stall);
  for (genvar i = 0; i < 5; i++) begin : g_m
    master_model mm_u (.core_clk, .start(start[i]), .target(tgt[i]), .stall(master_stall[i]),
      .req(master_req[i]));
  end
  task automatic step(input int n = 1);
    repeat (n) @(negedge core_clk);
  endtask : step
  task automatic chk_owner(input string what, input slave_state_t exp, input slave_state_t got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_owner
  task automatic chk_stall(input string what, input logic [4:0] exp, input logic [4:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_stall
  task automatic go(input int a, input int b, input logic [2:0] sa, input logic [2:0] sb);
    start <= (5'h1 << a) | (5'h1 << b);
    tgt[a] <= sa;
    tgt[b] <= sb;
    step();
    start <= '0;
    step();
  endtask : go
  task automatic free(input int m);
    for (int k = 0; k < 9 && master_req[m].req; k++) step();
    step();
  endtask : free
  task automatic cfg(input cfg_sel_t sel, input logic [2:0] s, input logic [31:0] d);
    cfg_wr <= {1'b1, sel, s, d};
    step();
    cfg_wr <= '0;
    step();
  endtask : cfg
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  // Loss of slave 0 shows both in the owner field and in the stall vector.
  task automatic test_contend;
    go(1, 2, 3'h0, 3'h0);
    chk_owner("owner0", 4'h9, slave_state[0]);
    chk_stall("stall", 5'h04, master_stall);
    free(1);
    chk_owner("owner0", 4'hA, slave_state[0]);
    free(2);
    go(0, 4, 3'h1, 3'h1);
    chk_owner("owner1", 4'h8, slave_state[1]);
    chk_stall("stall", 5'h10, master_stall);
    free(0);
    free(4);
    $display("contend end");
  endtask : test_contend
  task automatic test_parallel;
    go(0, 1, 3'h5, 3'h1);
    chk_stall("stall", 5'h00, master_stall);
    chk_owner("owner5", 4'h8, slave_state[5]);
    chk_owner("owner1", 4'h9, slave_state[1]);
    free(1);
    $display("parallel end");
  endtask : test_parallel
  // Masters 3 and 4 share level zero after the priority load; 4 must win.
  task automatic test_config;
    cfg(SEL_CONTROL, 3'h3, 32'h0000_0004);
    chk_owner("park3", 4'h4, slave_state[3]);
    cfg(SEL_PRIORITY, 3'h0, 32'h0000_0321);
    go(1, 4, 3'h0, 3'h0);
    chk_owner("owner0", 4'hC, slave_state[0]);
    free(4);
    free(1);
    go(3, 4, 3'h0, 3'h0);
    chk_owner("owner0", 4'hC, slave_state[0]);
    chk_stall("stall", 5'h08, master_stall);
    free(4);
    free(3);
    $display("config end");
  endtask : test_config
  task automatic test_rotate;
    cfg(SEL_CONTROL, 3'h2, 32'h0000_0101);
    go(1, 3, 3'h2, 3'h2);
    chk_owner("owner2", 4'hB, slave_state[2]);
    chk_stall("stall", 5'h02, master_stall);
    free(3);
    free(1);
    $display("rotate end");
  endtask : test_rotate
  initial begin
    step(12);
    srst <= 1'b0;
    step();
    test_contend();
    test_parallel();
    test_config();
    test_rotate();
    conclude();
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      conclude();
    end
  end
endmodule : testbench
